// ---- design/cal_loop.sv ----
// One automatic correction loop: refreshes or holds its correction word.
// Assumes a one-cycle update pulse from the line-rate divider outside.
`timescale 1ns/100ps
module cal_loop (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic                            run,
  input  wire logic                            update,
  input  wire logic [cal_ctrl_pkg::CORR_W-1:0] target,
  output logic      [cal_ctrl_pkg::CORR_W-1:0] corr,
  output logic                                 settled
);
  import cal_ctrl_pkg::*;

  logic [3:0]      steps_q;
  logic            step;
  logic            upward;
  logic [CORR_W:0] sum;

  assign step   = run && update;
  // Rounding toward the target keeps every step moving, upward or down;
  // rounding one fixed way would stall one count short when descending.
  assign upward = (corr < target);
  assign sum    = {1'b0, corr} + {1'b0, target} + {{CORR_W{1'b0}}, upward};

  // Each update moves halfway to the target, except the tenth since the loop
  // started, which loads the target outright; so ten updates always reach it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      corr    <= '0;
      steps_q <= '0;
    end else if (!run) begin
      steps_q <= '0;
    end else if (step) begin
      if (corr == target) begin
        corr <= corr;
      end else if (steps_q == 4'(SETTLE_UPDATES - 1)) begin
        corr <= target;
      end else begin
        corr <= sum[CORR_W:1];
      end
      if (steps_q != 4'(SETTLE_UPDATES)) begin
        steps_q <= steps_q + 4'h1;
      end
    end
  end

  assign settled = (steps_q == 4'(SETTLE_UPDATES)) || (corr == target);
endmodule

// ---- design/calibration_hold_test_controls.sv ----
// AXI4-Lite register bank for calibration hold and front-end options.
// Assumes a single 125 MHz clock; update pulses come from outside.
//
// Functional notes
// - Offset hold bit 0 lets offset correction refresh at every update.
// - Offset hold bit 1 stops offset refreshes and keeps the last values.
// - With filter enabled, green sync pulses shorter than 250 ns are blocked.
// - The green sync filter enable resets cleared, filtering off.
// - VCO gear bit 0 selects normal range, 1 selects low range.
// - Gain hold bit 1 lets gain matching refresh continuously.
// - Gain hold bit 0, the reset state, freezes gain matching values.
// - Gain enable field 000 disables, 110 enables automatic gain matching.
// - Gain matching settles within ten update intervals.
`timescale 1ns/100ps
module calibration_hold_test_controls (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [cal_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [cal_ctrl_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [cal_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [cal_ctrl_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic                            auto_offset_enable,
  input  wire logic                            cal_update,
  input  wire logic [cal_ctrl_pkg::CORR_W-1:0] offset_target,
  input  wire logic [cal_ctrl_pkg::CORR_W-1:0] gain_target,
  input  wire logic                            green_channel_sync,
  output logic                                 green_sync_to_pll,
  output logic                                 vco_low_gear,
  output logic [cal_ctrl_pkg::CORR_W-1:0]      offset_corr,
  output logic [cal_ctrl_pkg::CORR_W-1:0]      gain_corr
);
  import cal_ctrl_pkg::*;

  logic [REG_W-1:0]  offset_hold_q, test_five_q, test_six_q;
  logic [REG_W-1:0]  green_filter_q, vco_range_q, gain_match_q;
  logic              aw_held_q, w_held_q;
  logic [5:0]        aw_idx_q;
  logic [REG_W-1:0]  wdata_q;
  logic              wstrb_q;
  logic              bvalid_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [DATA_W-1:0] rdata_q;
  logic              offset_settled, gain_settled;

  wire             do_write = aw_held_q && w_held_q && !bvalid_q;
  wire [5:0]       ar_idx   = s_axi_araddr[ADDR_W-1:2];
  wire             wr_lane  = wstrb_q;
  wire             offset_run = auto_offset_enable &&
                                !offset_hold_q[OFS_HOLD_BIT];
  wire             gain_on  =
    gain_match_q[GAIN_EN_LSB +: GAIN_EN_W] == GAIN_EN_ON;
  wire             gain_run = gain_on && gain_match_q[GAIN_HOLD_BIT];
  wire             wr_hit   =
    (aw_idx_q == IDX_OFFSET_HOLD) || (aw_idx_q == IDX_TEST_FIVE) ||
    (aw_idx_q == IDX_TEST_SIX) || (aw_idx_q == IDX_GREEN_FILTER) ||
    (aw_idx_q == IDX_VCO_RANGE) || (aw_idx_q == IDX_GAIN_MATCH);
  wire [REG_W-1:0] status_byte = {6'h00, gain_settled, offset_settled};

  logic [REG_W-1:0] rd_byte;
  logic             rd_hit;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (ar_idx == IDX_OFFSET_HOLD) begin
      rd_byte = offset_hold_q;
    end else if (ar_idx == IDX_TEST_FIVE) begin
      rd_byte = test_five_q;
    end else if (ar_idx == IDX_TEST_SIX) begin
      rd_byte = test_six_q;
    end else if (ar_idx == IDX_GREEN_FILTER) begin
      rd_byte = green_filter_q;
    end else if (ar_idx == IDX_VCO_RANGE) begin
      rd_byte = vco_range_q;
    end else if (ar_idx == IDX_GAIN_MATCH) begin
      rd_byte = gain_match_q;
    end else if (ar_idx == IDX_CAL_STATUS) begin
      rd_byte = status_byte;
    end else begin
      rd_hit  = 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // Address and data are caught independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= 6'h00;
    end else if (s_axi_awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[ADDR_W-1:2];
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 8'h00;
      wstrb_q  <= 1'b0;
    end else if (s_axi_wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata[REG_W-1:0];
      wstrb_q  <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Each register is its own byte, so a write touches only its target.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_hold_q  <= RST_OFFSET_HOLD;
      test_five_q    <= RST_TEST_FIVE;
      test_six_q     <= RST_TEST_SIX;
      green_filter_q <= RST_GREEN_FILTER;
      vco_range_q    <= RST_VCO_RANGE;
      gain_match_q   <= RST_GAIN_MATCH;
    end else if (do_write && wr_lane) begin
      if (aw_idx_q == IDX_OFFSET_HOLD) begin
        offset_hold_q  <= wdata_q;
      end
      if (aw_idx_q == IDX_TEST_FIVE) begin
        test_five_q    <= wdata_q;
      end
      if (aw_idx_q == IDX_TEST_SIX) begin
        test_six_q     <= wdata_q;
      end
      if (aw_idx_q == IDX_GREEN_FILTER) begin
        green_filter_q <= wdata_q;
      end
      if (aw_idx_q == IDX_VCO_RANGE) begin
        vco_range_q    <= wdata_q;
      end
      if (aw_idx_q == IDX_GAIN_MATCH) begin
        gain_match_q   <= wdata_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rd_byte};
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  cal_loop offset_loop (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (offset_run),
    .update  (cal_update),
    .target  (offset_target),
    .corr    (offset_corr),
    .settled (offset_settled)
  );

  cal_loop gain_loop (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (gain_run),
    .update  (cal_update),
    .target  (gain_target),
    .corr    (gain_corr),
    .settled (gain_settled)
  );

  green_sync_filter sync_filter (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .enable             (green_filter_q[GREEN_FILT_BIT]),
    .green_channel_sync (green_channel_sync),
    .sync_out           (green_sync_to_pll)
  );

  assign vco_low_gear = vco_range_q[VCO_GEAR_BIT];

  property p_offset_hold;
    @(posedge aclk) disable iff (!aresetn)
      offset_hold_q[OFS_HOLD_BIT] |=> $stable(offset_corr);
  endproperty
  a_offset_hold: assert property (p_offset_hold)
    else $error("Offset correction changed while held.");

  property p_offset_run;
    @(posedge aclk) disable iff (!aresetn)
      (offset_run && cal_update && offset_corr != offset_target)
        |=> offset_corr != $past(offset_corr);
  endproperty
  a_offset_run: assert property (p_offset_run)
    else $error("Offset correction did not refresh on update.");

  property p_gain_freeze;
    @(posedge aclk) disable iff (!aresetn)
      !gain_match_q[GAIN_HOLD_BIT] |=> $stable(gain_corr);
  endproperty
  a_gain_freeze: assert property (p_gain_freeze)
    else $error("Gain values changed while frozen.");

  property p_gain_run;
    @(posedge aclk) disable iff (!aresetn)
      (gain_run && cal_update && gain_corr != gain_target)
        |=> gain_corr != $past(gain_corr);
  endproperty
  a_gain_run: assert property (p_gain_run)
    else $error("Gain values did not refresh on update.");

  // Updates taken since the gain loop last started, kept apart from the
  // loop's own count so that the settle bound is checked from outside.
  logic [3:0] gain_upd_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || !gain_run) begin
      gain_upd_q <= 4'h0;
    end else if (cal_update && gain_upd_q != 4'(SETTLE_UPDATES)) begin
      gain_upd_q <= gain_upd_q + 4'h1;
    end
  end

  property p_gain_settle;
    @(posedge aclk) disable iff (!aresetn)
      (gain_run && cal_update && gain_upd_q == 4'(SETTLE_UPDATES - 1))
        |=> gain_corr == $past(gain_target);
  endproperty
  a_gain_settle: assert property (p_gain_settle)
    else $error("Gain matching did not settle within ten updates.");

  property p_gain_disabled;
    @(posedge aclk) disable iff (!aresetn)
      (gain_match_q[GAIN_EN_LSB +: GAIN_EN_W] == GAIN_EN_OFF)
        |=> $stable(gain_corr);
  endproperty
  a_gain_disabled: assert property (p_gain_disabled)
    else $error("Gain matching ran while disabled.");

  property p_vco_gear;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && wr_lane && aw_idx_q == IDX_VCO_RANGE)
        |=> (vco_range_q == $past(wdata_q)) &&
            (vco_low_gear == vco_range_q[VCO_GEAR_BIT]);
  endproperty
  a_vco_gear: assert property (p_vco_gear)
    else $error("VCO gear output disagrees with its register.");

  property p_filter_reset;
    @(posedge aclk) $rose(aresetn) |-> !green_filter_q[GREEN_FILT_BIT];
  endproperty
  a_filter_reset: assert property (p_filter_reset)
    else $error("Green sync filter enable not cleared after reset.");

  property p_write_isolated;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && aw_idx_q != IDX_VCO_RANGE) |=> $stable(vco_range_q);
  endproperty
  a_write_isolated: assert property (p_write_isolated)
    else $error("Write disturbed an unrelated register.");
endmodule

// ---- design/green_sync_filter.sv ----
// Pulse-width filter on the green-channel sync input.
// Assumes an asynchronous pin input; it is synchronised here.
`timescale 1ns/100ps
module green_sync_filter (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable,
  input  wire logic green_channel_sync,
  output logic      sync_out
);
  import cal_ctrl_pkg::*;

  logic                   s1_q, s2_q, s3_q;
  logic                   stable_q;
  logic [GREEN_CNT_W-1:0] width_q;
  logic [GREEN_CNT_W-1:0] high_run_q;
  logic                   agree;
  logic                   wide;

  assign agree = (s2_q == s3_q);
  assign wide  = (width_q >= GREEN_CNT_W'(GREEN_MIN_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= green_channel_sync;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A high pulse only passes once it has lasted the minimum width, so
  // short pulses never reach the PLL; the cost is a fixed delay.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      width_q  <= '0;
      stable_q <= 1'b0;
    end else if (!(agree && s3_q)) begin
      width_q  <= '0;
      stable_q <= 1'b0;
    end else if (!wide) begin
      width_q  <= width_q + GREEN_CNT_W'(1);
    end else begin
      stable_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= enable ? stable_q : s3_q;
    end
  end

  property p_short_blocked;
    @(posedge aclk) disable iff (!aresetn)
      (enable && !s3_q) |=> !sync_out;
  endproperty
  a_short_blocked: assert property (p_short_blocked)
    else $error("Short green sync pulse passed the filter.");

  // Plain count of the synchronised input's high time, for checking only.
  always_ff @(posedge aclk) begin
    if (!aresetn || !s3_q) begin
      high_run_q <= '0;
    end else if (high_run_q != '1) begin
      high_run_q <= high_run_q + GREEN_CNT_W'(1);
    end
  end

  property p_min_width;
    @(posedge aclk) disable iff (!aresetn)
      ($past(enable) && $rose(sync_out))
        |-> $past(high_run_q) >= GREEN_CNT_W'(GREEN_MIN_CYC);
  endproperty
  a_min_width: assert property (p_min_width)
    else $error("Green sync pulse passed before its minimum width.");
endmodule

// ---- include/cal_ctrl_pkg.sv ----
// Constants shared by the calibration and front-end control register bank.
// Assumes a single 125 MHz clock and AXI4-Lite with 32-bit data.
package cal_ctrl_pkg;
  localparam int unsigned CLK_PERIOD_NS       = 8;
  localparam int unsigned ADDR_W              = 8;
  localparam int unsigned DATA_W              = 32;
  localparam int unsigned REG_W               = 8;

  // Register offsets are not all multiples of four, so they are indices.
  localparam logic [5:0] IDX_OFFSET_HOLD      = 6'h2C;
  localparam logic [5:0] IDX_TEST_FIVE        = 6'h2D;
  localparam logic [5:0] IDX_TEST_SIX         = 6'h2E;
  localparam logic [5:0] IDX_GREEN_FILTER     = 6'h34;
  localparam logic [5:0] IDX_VCO_RANGE        = 6'h36;
  localparam logic [5:0] IDX_GAIN_MATCH       = 6'h3C;
  localparam logic [5:0] IDX_CAL_STATUS       = 6'h3F;

  localparam int unsigned OFS_HOLD_BIT        = 4;
  localparam int unsigned GREEN_FILT_BIT      = 2;
  localparam int unsigned VCO_GEAR_BIT        = 0;
  localparam int unsigned GAIN_HOLD_BIT       = 3;
  localparam int unsigned GAIN_EN_LSB         = 0;
  localparam int unsigned GAIN_EN_W           = 3;
  localparam logic [2:0]  GAIN_EN_OFF         = 3'h0;
  localparam logic [2:0]  GAIN_EN_ON          = 3'h6;

  localparam logic [7:0] RST_OFFSET_HOLD      = 8'h00;
  localparam logic [7:0] RST_TEST_FIVE        = 8'h00;
  localparam logic [7:0] RST_TEST_SIX         = 8'h00;
  localparam logic [7:0] RST_GREEN_FILTER     = 8'h00;
  localparam logic [7:0] RST_VCO_RANGE        = 8'h00;
  localparam logic [7:0] RST_GAIN_MATCH       = 8'h00;

  localparam int unsigned SETTLE_UPDATES      = 10;
  localparam int unsigned GREEN_MIN_NS        = 250;
  localparam int unsigned GREEN_MIN_CYC       =
    (GREEN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GREEN_CNT_W         = 6;
  localparam int unsigned CORR_W              = 10;

  localparam logic [1:0] RESP_OKAY            = 2'h0;
  localparam logic [1:0] RESP_SLVERR          = 2'h2;
endpackage

// ---- testbench/tb.sv ----
// Self-checking bench for the calibration hold and front-end register bank.
// Assumes the bank answers on AXI4-Lite and its loops step on cal_update.
`timescale 1ns/100ps
module tb;
  import cal_ctrl_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bvalid, bready;
  logic        awready, wready, arready, arvalid, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        ofs_en, cal_update, gsync, gsync_out, vco_low;
  logic [9:0]  ofs_tgt, gain_tgt, ofs_corr, gain_corr;
  int          n_mismatch, cmp_count;
  logic [7:0]  v;
  logic [1:0]  r;
  logic        seen;

  calibration_hold_test_controls i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .auto_offset_enable(ofs_en),
    .cal_update(cal_update), .offset_target(ofs_tgt),
    .gain_target(gain_tgt), .green_channel_sync(gsync),
    .green_sync_to_pll(gsync_out), .vco_low_gear(vco_low),
    .offset_corr(ofs_corr), .gain_corr(gain_corr));

  always #4 aclk = ~aclk;

  task give_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Register index to byte address: one word per register.
  function automatic logic [7:0] ad(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 || n > 100) break;
    end
    if (n > 100) chk("write handshake", 1, 0);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 || n > 100) break;
    end
    if (n > 100) chk("read handshake", 1, 0);
    v = rdata[7:0];
    r = rresp;
    chk("rdata upper", 24'h000000, rdata[31:8]);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task upd(input int n);
    repeat (n) begin
      cal_update <= 1'b1;
      @(posedge aclk);
      cal_update <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task pulse(input int len);
    seen = 1'b0;
    gsync <= 1'b1;
    for (int i = 0; i < len + 12; i++) begin
      @(posedge aclk);
      if (i == len - 1) gsync <= 1'b0;
      if (gsync_out === 1'b1) seen = 1'b1;
    end
  endtask

  task t_reset_and_bus;
    logic [5:0] idx [6];
    logic [7:0] rv [6];
    idx = '{IDX_OFFSET_HOLD, IDX_TEST_FIVE, IDX_TEST_SIX, IDX_GREEN_FILTER,
            IDX_VCO_RANGE, IDX_GAIN_MATCH};
    rv = '{RST_OFFSET_HOLD, RST_TEST_FIVE, RST_TEST_SIX, RST_GREEN_FILTER,
           RST_VCO_RANGE, RST_GAIN_MATCH};
    for (int i = 0; i < 6; i++) begin
      rd(ad(idx[i]));
      chk("reset value", rv[i], v);
    end
    wr(8'h00, 8'h5A, 4'hF);
    chk("unmapped bresp", RESP_SLVERR, r);
    rd(8'h00);
    chk("unmapped rresp", RESP_SLVERR, r);
    wr(ad(IDX_TEST_FIVE), 8'hE8, 4'hF);
    wr(ad(IDX_TEST_SIX), 8'hE0, 4'hF);
    rd(ad(IDX_TEST_FIVE));
    chk("test byte five", 8'hE8, v);
    rd(ad(IDX_TEST_SIX));
    chk("test byte six", 8'hE0, v);
  endtask

  task t_vco;
    wr(ad(IDX_VCO_RANGE), 8'hA1, 4'hF);
    chk("vco low gear", 1, vco_low);
    wr(ad(IDX_VCO_RANGE), 8'h00, 4'h0);
    chk("masked bresp", RESP_OKAY, r);
    rd(ad(IDX_VCO_RANGE));
    chk("vco reg kept", 8'hA1, v);
    wr(ad(IDX_VCO_RANGE), 8'hA0, 4'hF);
    chk("vco normal", 0, vco_low);
    rd(ad(IDX_VCO_RANGE));
    chk("vco reg others", 8'hA0, v);
  endtask

  task t_offset;
    ofs_en <= 1'b1;
    ofs_tgt <= 10'h155;
    wr(ad(IDX_OFFSET_HOLD), 8'h00, 4'hF);
    upd(SETTLE_UPDATES);
    chk("offset settled", 10'h155, ofs_corr);
    wr(ad(IDX_OFFSET_HOLD), 8'h10, 4'hF);
    ofs_tgt <= 10'h2AA;
    upd(3);
    chk("offset held", 10'h155, ofs_corr);
    wr(ad(IDX_OFFSET_HOLD), 8'h00, 4'hF);
    upd(SETTLE_UPDATES);
    chk("offset resumed", 10'h2AA, ofs_corr);
  endtask

  task t_gain;
    gain_tgt <= 10'h3C3;
    wr(ad(IDX_GAIN_MATCH), 8'h06, 4'hF);
    upd(3);
    chk("gain frozen at hold 0", 10'h000, gain_corr);
    wr(ad(IDX_GAIN_MATCH), 8'h0E, 4'hF);
    upd(SETTLE_UPDATES);
    chk("gain settled", 10'h3C3, gain_corr);
    rd(ad(IDX_CAL_STATUS));
    chk("settled flags", 8'h03, v);
    wr(ad(IDX_GAIN_MATCH), 8'h06, 4'hF);
    gain_tgt <= 10'h0F0;
    upd(3);
    chk("gain held", 10'h3C3, gain_corr);
    wr(ad(IDX_GAIN_MATCH), 8'h08, 4'hF);
    upd(3);
    chk("gain disabled", 10'h3C3, gain_corr);
    rd(ad(IDX_GAIN_MATCH));
    chk("gain reg", 8'h08, v);
  endtask

  task t_filter;
    pulse(5);
    chk("unfiltered pass", 1, seen);
    wr(ad(IDX_GREEN_FILTER), 8'h04, 4'hF);
    pulse(20);
    chk("short pulse blocked", 0, seen);
    pulse(GREEN_MIN_CYC - 1);
    chk("pulse under 250 ns blocked", 0, seen);
    pulse(GREEN_MIN_CYC + 20);
    chk("long pulse passed", 1, seen);
  endtask

  // A reset in mid-run must bring back the power-up state, after which a
  // single offset calibration has to be repeated.
  task t_power_up;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("gain after reset", 10'h000, gain_corr);
    rd(ad(IDX_GREEN_FILTER));
    chk("filter after reset", RST_GREEN_FILTER, v);
    rd(ad(IDX_GAIN_MATCH));
    chk("gain reg after reset", RST_GAIN_MATCH, v);
    wr(ad(IDX_OFFSET_HOLD), 8'h00, 4'hF);
    upd(SETTLE_UPDATES);
    chk("offset recalibrated", 10'h2AA, ofs_corr);
    wr(ad(IDX_OFFSET_HOLD), 8'h10, 4'hF);
    ofs_tgt <= 10'h155;
    upd(2);
    chk("offset frozen", 10'h2AA, ofs_corr);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    {ofs_en, cal_update, gsync} = '0;
    ofs_tgt = 10'h000;
    gain_tgt = 10'h000;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_and_bus;
    t_vco;
    t_offset;
    t_gain;
    t_filter;
    t_power_up;
    give_verdict;
  end

  // The whole run needs a few hundred cycles; this leaves wide margin.
  initial begin
    #(CLK_PERIOD_NS * 20000);
    n_mismatch++;
    give_verdict;
  end
endmodule
